// [hdl/dlc_pkg.sv]
package dlc_pkg;
  // =====================================================================
  // opcodes in the top byte of a command word
  localparam logic [7:0] OP_END_LIST = 8'h00;
  localparam logic [7:0] OP_WIPE_RGB = 8'h02;
  localparam logic [7:0] OP_DRAW_RGB = 8'h04;
  localparam logic [7:0] OP_WIPE_TAG = 8'h06;
  localparam logic [7:0] OP_WIPE_A = 8'h0f;
  localparam logic [7:0] OP_DRAW_A = 8'h10;
  localparam logic [7:0] OP_WIPE_STEN = 8'h11;
  localparam logic [7:0] OP_CHAN_MASK = 8'h20;
  localparam logic [7:0] OP_PRIM_CLOSE = 8'h21;
  localparam logic [7:0] OP_CTX_SAVE = 8'h22;
  localparam logic [7:0] OP_CTX_LOAD = 8'h23;
  localparam logic [7:0] OP_WIPE_BUF = 8'h26;
  // =====================================================================
  // field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 24;
  localparam int CH_HI_HI = 23;
  localparam int CH_HI_LO = 16;
  localparam int CH_MID_HI = 15;
  localparam int CH_MID_LO = 8;
  localparam int CH_LO_HI = 7;
  localparam int CH_LO_LO = 0;
  localparam int WIPE_COLOR_BIT = 2;
  localparam int WIPE_STEN_BIT = 1;
  localparam int WIPE_TAG_BIT = 0;
  // =====================================================================
  // reset values
  localparam logic [7:0] WIPE_RST = 8'h00;
  localparam logic [7:0] DRAW_RST = 8'hff;
  localparam logic [3:0] MASK_RST = 4'hf;
  // context image width: 4 mask + 4 draw + 6 wipe bytes
  localparam int CTX_W = 4 + 10 * 8;
  localparam int CTX_DEPTH = 4;
endpackage

// [hdl/dlc_decoder.sv]
`timescale 1ns/1ps
module dlc_decoder
  import dlc_pkg::*;
#(
  parameter int DEPTH = CTX_DEPTH
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic start_i,        // begin a new list
  input wire logic cmd_valid_i,    // command word offered
  input wire logic [31:0] cmd_word_i,
  output logic cmd_ready_o,        // word accepted in the previous cycle
  output logic list_done_o,        // end-of-list seen
  output logic prim_close_o,       // pulse: primitive closed
  output logic wipe_color_o,       // pulse: fill color buffer
  output logic wipe_sten_o,        // pulse: fill stencil buffer
  output logic wipe_tag_o,         // pulse: fill tag buffer
  output logic [7:0] wipe_red_o,
  output logic [7:0] wipe_green_o,
  output logic [7:0] wipe_blue_o,
  output logic [7:0] wipe_alpha_o,
  output logic [7:0] wipe_sten_val_o,
  output logic [7:0] wipe_tag_val_o,
  output logic [7:0] draw_red_o,
  output logic [7:0] draw_green_o,
  output logic [7:0] draw_blue_o,
  output logic [7:0] draw_alpha_o,
  output logic [3:0] chan_en_o     // {red, green, blue, alpha}
);

  // =====================================================================
  // command decode
  typedef enum logic [0:0] {
    RUN,
    DONE
  } dlc_state_type;

  dlc_state_type state_r;          // list running or finished
  logic [7:0] opc;                 // top byte only; reserved ignored
  logic take;                      // word consumed this cycle
  assign opc = cmd_word_i[OPC_HI:OPC_LO];
  // after end-of-list every word is dropped unseen
  assign take = cmd_valid_i && (state_r == RUN);

  function automatic logic is_op(input logic [7:0] o,
                                 input logic [7:0] ref_op);
    is_op = (o == ref_op);
  endfunction

  logic do_end, do_wrgb, do_drgb, do_wtag, do_wa, do_da, do_wst;
  logic do_mask, do_close, do_save, do_load, do_wipe;
  assign do_end = take && is_op(opc, OP_END_LIST);
  assign do_wrgb = take && is_op(opc, OP_WIPE_RGB);
  assign do_drgb = take && is_op(opc, OP_DRAW_RGB);
  assign do_wtag = take && is_op(opc, OP_WIPE_TAG);
  assign do_wa = take && is_op(opc, OP_WIPE_A);
  assign do_da = take && is_op(opc, OP_DRAW_A);
  assign do_wst = take && is_op(opc, OP_WIPE_STEN);
  assign do_mask = take && is_op(opc, OP_CHAN_MASK);
  assign do_close = take && is_op(opc, OP_PRIM_CLOSE);
  assign do_save = take && is_op(opc, OP_CTX_SAVE);
  assign do_load = take && is_op(opc, OP_CTX_LOAD);
  assign do_wipe = take && is_op(opc, OP_WIPE_BUF);

  logic [7:0] b_hi, b_mid, b_lo;   // byte fields of the word
  assign b_hi = cmd_word_i[CH_HI_HI:CH_HI_LO];
  assign b_mid = cmd_word_i[CH_MID_HI:CH_MID_LO];
  assign b_lo = cmd_word_i[CH_LO_HI:CH_LO_LO];

  // =====================================================================
  // list state: end-of-list holds until a fresh start
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= RUN;
    end else if (start_i) begin
      state_r <= RUN;
    end else if (do_end) begin
      state_r <= DONE;
    end
  end

  // =====================================================================
  // graphics context: current state packed into one image
  logic [CTX_W-1:0] ctx_r, ctx_nxt, ctx_dflt, ctx_pop;
  assign ctx_dflt = {MASK_RST, DRAW_RST, DRAW_RST, DRAW_RST, DRAW_RST,
                     WIPE_RST, WIPE_RST, WIPE_RST, WIPE_RST, WIPE_RST,
                     WIPE_RST};

  // field views of the current image
  logic [3:0] c_mask;
  logic [7:0] c_dr, c_dg, c_db, c_da, c_wr, c_wg, c_wb, c_wa, c_ws, c_wt;
  assign {c_mask, c_dr, c_dg, c_db, c_da,
          c_wr, c_wg, c_wb, c_wa, c_ws, c_wt} = ctx_r;

  // next image: each command but a restore rewrites only its own field
  always_comb begin
    ctx_nxt = {
      do_mask ? cmd_word_i[3:0] : c_mask,     // r,g,b,a order
      do_drgb ? b_hi : c_dr,
      do_drgb ? b_lo : c_dg,                  // green low byte
      do_drgb ? b_mid : c_db,                 // blue middle byte
      do_da ? b_lo : c_da,
      do_wrgb ? b_hi : c_wr,
      do_wrgb ? b_lo : c_wg,                  // printed layout
      do_wrgb ? b_mid : c_wb,
      do_wa ? b_lo : c_wa,
      do_wst ? b_lo : c_ws,
      do_wtag ? b_lo : c_wt};
    if (do_load) begin
      ctx_nxt = ctx_pop;
    end
  end

  // =====================================================================
  // context stack: save drops the oldest when full
  logic [CTX_W-1:0] stk_r [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] used_r;         // levels held
  localparam logic [$clog2(DEPTH+1)-1:0] USED_MAX =
    ($clog2(DEPTH+1))'(DEPTH);
  // empty stack hands back defaults
  assign ctx_pop = (used_r != '0) ? stk_r[0] : ctx_dflt;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_stk
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stk_r[gi] <= '0;
        end else if (do_save) begin
          // push: shift toward deeper slots, newest at slot 0
          stk_r[gi] <= (gi == 0) ? ctx_r : stk_r[(gi == 0) ? 0 : gi-1];
        end else if (do_load) begin
          stk_r[gi] <= (gi == DEPTH-1) ? '0 :
                       stk_r[(gi == DEPTH-1) ? gi : gi+1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      used_r <= '0;
    end else if (do_save && used_r != USED_MAX) begin
      used_r <= used_r + 1'b1;
    end else if (do_load && used_r != '0) begin
      used_r <= used_r - 1'b1;
    end
  end

  // state register; a new list does not disturb held context
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctx_r <= {MASK_RST, DRAW_RST, DRAW_RST, DRAW_RST, DRAW_RST,
                WIPE_RST, WIPE_RST, WIPE_RST, WIPE_RST, WIPE_RST,
                WIPE_RST};
    end else begin
      ctx_r <= ctx_nxt;
    end
  end

  // =====================================================================
  // event pulses; buffer fill samples the clear values of this cycle
  logic wc_nxt, ws_nxt, wt_nxt;
  assign wc_nxt = do_wipe && cmd_word_i[WIPE_COLOR_BIT];
  assign ws_nxt = do_wipe && cmd_word_i[WIPE_STEN_BIT];
  assign wt_nxt = do_wipe && cmd_word_i[WIPE_TAG_BIT];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wipe_color_o <= 1'b0;
      wipe_sten_o <= 1'b0;
      wipe_tag_o <= 1'b0;
      prim_close_o <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else begin
      wipe_color_o <= wc_nxt;
      wipe_sten_o <= ws_nxt;
      wipe_tag_o <= wt_nxt;
      // close is optional: nothing waits on it, so omission is safe
      prim_close_o <= do_close;
      cmd_ready_o <= take;
    end
  end

  // =====================================================================
  // outputs: state image mirrored straight from flip-flops
  assign list_done_o = (state_r == DONE);
  assign {chan_en_o, draw_red_o, draw_green_o, draw_blue_o,
          draw_alpha_o} = ctx_r[CTX_W-1:48];
  assign {wipe_red_o, wipe_green_o, wipe_blue_o, wipe_alpha_o,
          wipe_sten_val_o, wipe_tag_val_o} = ctx_r[47:0];

  // =====================================================================
  // checks
  wipe_alpha_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_wa |=> wipe_alpha_o == $past(b_lo))
    else $error("clear alpha not loaded");

  wipe_rgb_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_wrgb |=> wipe_red_o == $past(b_hi) &&
                  wipe_blue_o == $past(b_mid) &&
                  wipe_green_o == $past(b_lo))
    else $error("clear rgb not loaded");

  wipe_sten_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_wst |=> wipe_sten_val_o == $past(b_lo))
    else $error("stencil clear not loaded");

  wipe_tag_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_wtag |=> wipe_tag_val_o == $past(b_lo))
    else $error("tag clear not loaded");

  draw_alpha_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_da |=> draw_alpha_o == $past(b_lo))
    else $error("draw alpha not loaded");

  chan_mask_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_mask |=> chan_en_o == $past(cmd_word_i[3:0]))
    else $error("channel enables not loaded");

  draw_rgb_load_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_drgb |=> draw_green_o == $past(b_lo) &&
                  draw_blue_o == $past(b_mid) &&
                  draw_red_o == $past(b_hi))
    else $error("draw rgb not loaded");

  list_end_hold_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      list_done_o && !start_i |=> list_done_o && !cmd_ready_o)
    else $error("word taken after end of list");

  prim_close_pulse_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_close ##1 !do_close |-> prim_close_o ##1 !prim_close_o)
    else $error("primitive close pulse wrong");

  color_wipe_gate_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_wipe && !cmd_word_i[WIPE_COLOR_BIT] |=> !wipe_color_o)
    else $error("color fill without color bit");

  ctx_over_pop_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_load && used_r == '0 |=> draw_alpha_o == DRAW_RST &&
                                  chan_en_o == MASK_RST)
    else $error("empty restore did not load defaults");

  // =====================================================================
  // hold and handshake checks
  // a fill must see the clear values as they stand, not a later update
  color_fill_hold_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      do_wipe && cmd_word_i[WIPE_COLOR_BIT] |=> wipe_color_o &&
        $stable(wipe_red_o) && $stable(wipe_green_o) &&
        $stable(wipe_blue_o) && $stable(wipe_alpha_o))
    else $error("clear color moved during fill");

  // draw color only moves on its own command or a restore
  draw_rgb_hold_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      !do_drgb && !do_load |=> $stable(draw_red_o) &&
        $stable(draw_green_o) && $stable(draw_blue_o))
    else $error("draw rgb changed without command");

  draw_alpha_hold_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      !do_da && !do_load |=> $stable(draw_alpha_o))
    else $error("draw alpha changed without command");

  chan_mask_hold_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      !do_mask && !do_load |=> $stable(chan_en_o))
    else $error("channel enables changed without command");

  // every offered word is taken while the list runs
  word_take_ack_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      cmd_valid_i && !list_done_o |=> cmd_ready_o)
    else $error("offered word not taken");

  idle_no_ack_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      !cmd_valid_i |=> !cmd_ready_o)
    else $error("acknowledge without a word");

  // a fresh start re-arms the decoder after end of list
  list_rearm_a: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
      start_i |=> !list_done_o)
    else $error("start did not re-arm list");

endmodule

// [tb/dlc_list_mem.sv]
`timescale 1ns/1ps
// =====================================================================
// display list memory: hands the decoder one command word at a time
module dlc_list_mem (
  input wire logic clock_i,
  input wire logic cmd_ready_i,
  output logic cmd_valid_o,
  output logic [31:0] cmd_word_o
);
  // idle at start: nothing offered
  initial begin
    cmd_valid_o = 1'b0;
    cmd_word_o = 32'h0;
  end
  // offer a word for one edge, then read the acknowledge pulse;
  // the word line toggles while idle so a stale word never looks valid
  task automatic send(input logic [31:0] w, input int gap,
                      output logic took);
    repeat (gap) begin
      @(posedge clock_i);
      cmd_word_o <= ~cmd_word_o;
    end
    @(posedge clock_i);
    cmd_valid_o <= 1'b1;
    cmd_word_o <= w;
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    cmd_word_o <= ~w;
    #1 took = cmd_ready_i;
  endtask
endmodule

// [tb/test_display_list_color_state_decoder.sv]
`timescale 1ns/1ps
module test_display_list_color_state_decoder;
  import dlc_pkg::*;
  // =====================================================================
  // signals
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  logic cmd_valid_i, cmd_ready_o, list_done_o, prim_close_o, took;
  logic wipe_color_o, wipe_sten_o, wipe_tag_o, exp_done;
  logic [31:0] cmd_word_i;
  logic [7:0] wipe_red_o, wipe_green_o, wipe_blue_o, wipe_alpha_o;
  logic [7:0] wipe_sten_val_o, wipe_tag_val_o;
  logic [7:0] draw_red_o, draw_green_o, draw_blue_o, draw_alpha_o;
  logic [3:0] chan_en_o;
  logic [83:0] st, exp_st;
  logic [83:0] stack[$]; // expected context store
  logic [83:0] dflt = {{6{WIPE_RST}}, {4{DRAW_RST}}, MASK_RST};
  logic [31:0] rnd = 32'h054f;
  logic [7:0] ops[12] = '{8'h02, 8'h04, 8'h06, 8'h0f, 8'h10, 8'h11,
    8'h20, 8'h21, 8'h22, 8'h23, 8'h26, 8'h7e}; // 7e: unknown opcode
  int errors = 0;
  int n_tests = 0;
  assign st = {wipe_red_o, wipe_green_o, wipe_blue_o, wipe_alpha_o,
    wipe_sten_val_o, wipe_tag_val_o, draw_red_o, draw_green_o,
    draw_blue_o, draw_alpha_o, chan_en_o};
  always #5 clock_i = ~clock_i;
  dlc_decoder i_dut (.clock_i, .reset_n_i, .start_i, .cmd_valid_i,
    .cmd_word_i, .cmd_ready_o, .list_done_o, .prim_close_o, .wipe_color_o,
    .wipe_sten_o, .wipe_tag_o, .wipe_red_o, .wipe_green_o, .wipe_blue_o,
    .wipe_alpha_o, .wipe_sten_val_o, .wipe_tag_val_o, .draw_red_o,
    .draw_green_o, .draw_blue_o, .draw_alpha_o, .chan_en_o);
  dlc_list_mem i_mem (.clock_i, .cmd_ready_i(cmd_ready_o),
    .cmd_valid_o(cmd_valid_i), .cmd_word_o(cmd_word_i));
  // =====================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string nm, input logic [83:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // expected effect of one taken word; green and blue swap in the word
  task automatic model(input logic [31:0] w);
    case (w[31:24])
      OP_END_LIST: exp_done = 1'b1;
      OP_WIPE_RGB: exp_st[83:60] = {w[23:16], w[7:0], w[15:8]};
      OP_WIPE_A: exp_st[59:52] = w[7:0];
      OP_WIPE_STEN: exp_st[51:44] = w[7:0];
      OP_WIPE_TAG: exp_st[43:36] = w[7:0];
      OP_DRAW_RGB: exp_st[35:12] = {w[23:16], w[7:0], w[15:8]};
      OP_DRAW_A: exp_st[11:4] = w[7:0];
      OP_CHAN_MASK: exp_st[3:0] = w[3:0];
      OP_CTX_SAVE: begin
        stack.push_back(exp_st);
        if (stack.size() > CTX_DEPTH) stack.delete(0);
      end
      OP_CTX_LOAD: exp_st = stack.size() ? stack.pop_back() : dflt;
      default: ;
    endcase
  endtask
  // send one word and compare pulses and state right after it is taken
  task automatic put(input logic [31:0] w);
    logic acc;
    logic [5:0] ef;
    acc = !exp_done;
    ef = {acc, 1'b0, acc && w[31:24] == OP_PRIM_CLOSE,
      {3{acc && w[31:24] == OP_WIPE_BUF}} & w[2:0]};
    if (acc) model(w);
    ef[4] = exp_done;
    i_mem.send(w, int'(rnd[1:0]), took);
    chk("flags", 84'(ef), 84'({took, list_done_o, prim_close_o,
      wipe_color_o, wipe_sten_o, wipe_tag_o}));
    chk("state", exp_st, st);
  endtask
  task automatic do_reset();
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    exp_st = dflt;
    exp_done = 1'b0;
    stack.delete();
    @(posedge clock_i);
    #1 chk("reset", dflt, st);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // =====================================================================
  // main sequence
  initial begin
    do_reset();
    put(32'h020a0b0c);
    put(32'h26000004);
    put(32'h26ff0003);
    put(32'h20fffff5);
    // five saves overflow the four-level store, six loads underflow it
    for (int i = 0; i < 5; i++) begin
      put({OP_DRAW_A, 24'(i)});
      put({OP_CTX_SAVE, 24'h0});
    end
    repeat (6) put({OP_CTX_LOAD, 24'h0});
    // random words with random reserved bits; closes may be missing
    repeat (300) begin
      rnd = xs(rnd);
      put({ops[rnd[27:24] % 12], rnd[23:0]});
    end
    put(32'h00123456);
    put(32'h0f0000aa);
    @(posedge clock_i);
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    exp_done = 1'b0;
    put(32'h0f0000aa);
    do_reset();
    end_of_test();
  end
  // watchdog: the run needs about 12 us
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
endmodule
